/* src/ssw_pkg.sv */
// Shared constants and carrier types for the supply supervisor block.
// Assumes a 100 MHz system clock and comparator results arriving as logic levels.
package ssw_pkg;

    // Clock rate and time base
    localparam int unsigned SSW_CLK_MHZ       = 100;
    localparam int unsigned SSW_CYC_PER_MS    = SSW_CLK_MHZ * 1000;
    // Reset stretch, typical figures (both above the 35 ms and 140 ms minimums)
    localparam int unsigned SSW_STRETCH_SHORT_MS = 50;
    localparam int unsigned SSW_STRETCH_LONG_MS  = 200;
    // Watchdog timeouts in ms
    localparam int unsigned SSW_WD_LONG_MS    = 1600;
    localparam int unsigned SSW_WD_SHORT_MS   = 100;
    // External time base: prescale and fixed counts of divided ticks
    localparam int unsigned SSW_EXT_DIV       = 64;
    localparam logic [5:0]  SSW_EXT_DIV_LAST  = 6'(SSW_EXT_DIV - 1);
    localparam logic [27:0] SSW_EXT_STRETCH   = 28'h0000010;
    localparam logic [27:0] SSW_EXT_WD_LONG   = 28'h0000200;
    localparam logic [27:0] SSW_EXT_WD_SHORT  = 28'h0000020;

    // Register map, byte addresses
    localparam logic [7:0]  SSW_CTRL_ADDR     = 8'h00;
    localparam logic [7:0]  SSW_STATUS_ADDR   = 8'h04;
    localparam int unsigned SSW_CTRL_LONG_BIT = 0;
    localparam logic        SSW_CTRL_RESET    = 1'b0;

    // Reset sequencer phases
    typedef enum logic [1:0] {
        SSW_HOLD,
        SSW_STRETCH,
        SSW_RUN
    } ssw_phase_t;

    // Comparator results
    typedef struct packed {
        logic supplyLow;    // Main supply below reset threshold
        logic backup;       // Switchover comparator: on backup supply
        logic pfAbove;      // Power-fail sense above reference
    } ssw_sense_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ssw_apb_req_t;

    // Pin outputs of the supervisor
    typedef struct packed {
        logic resetN;
        logic supplyOk;
        logic expiryN;
        logic powerFailFlag;
        logic backupActive;
        logic memSelectOutN;
    } ssw_pins_t;

endpackage

/* src/ssw_supervisor.sv */
// Digital core of a processor supply supervisor with watchdog and memory gating.
// Assumes all pin inputs synchronous to clk except the comparator results.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps

module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter int unsigned STRETCH_SHORT_CYC = SSW_STRETCH_SHORT_MS * SSW_CYC_PER_MS,
    parameter int unsigned STRETCH_LONG_CYC  = SSW_STRETCH_LONG_MS * SSW_CYC_PER_MS,
    parameter int unsigned WD_LONG_CYC       = SSW_WD_LONG_MS * SSW_CYC_PER_MS,
    parameter int unsigned WD_SHORT_CYC      = SSW_WD_SHORT_MS * SSW_CYC_PER_MS
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire ssw_pkg::ssw_sense_t sense,
    input  wire logic              kickHigh,
    input  wire logic              kickLow,
    input  wire logic              timebaseSelect,
    input  wire logic              timebaseInput,
    input  wire logic              memSelectInN,
    input  wire ssw_pkg::ssw_apb_req_t apbReq,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output ssw_pkg::ssw_pins_t     pins,
    output logic                   resetHigh
);
    import ssw_pkg::*;

    // Complete state of the block
    typedef struct packed {
        ssw_sense_t  syncA;
        ssw_sense_t  syncB;
        ssw_phase_t  phase;
        logic [27:0] cnt;
        logic [27:0] wdCnt;
        logic [1:0]  kickPrev;
        logic        firstPeriod;
        logic        expired;
        logic        internalTb;
        logic        tbPrev;
        logic [5:0]  div;
        logic        longVariant;
        logic [31:0] rdata;
        logic        rerr;
        ssw_pins_t   pins;
    } ssw_state_t;

    ssw_state_t st;
    ssw_state_t next_st;

    logic        bad;
    logic        tick;
    logic        kickFloat;
    logic        kickEdge;
    logic [27:0] stretchLimit;
    logic [27:0] wdLimit;
    logic        setupRd;
    logic        accessWr;

    // Supply faults and kick decoding
    always_comb begin
        bad       = st.syncB.supplyLow | st.syncB.backup;
        kickFloat = ~kickHigh & ~kickLow;
        kickEdge  = (st.kickPrev != {kickHigh, kickLow});
    end

    // Count limits; the long timeout also covers the first period after reset
    always_comb begin
        if (st.internalTb) begin
            stretchLimit = st.longVariant ? 28'(STRETCH_LONG_CYC)
                                          : 28'(STRETCH_SHORT_CYC);
            if (st.firstPeriod || timebaseInput) begin
                wdLimit = 28'(WD_LONG_CYC);
            end else begin
                wdLimit = 28'(WD_SHORT_CYC);
            end
        end else begin
            stretchLimit = SSW_EXT_STRETCH;
            wdLimit      = st.firstPeriod ? SSW_EXT_WD_LONG : SSW_EXT_WD_SHORT;
        end
    end

    // One tick per clock, or per 64 external rising edges
    always_comb begin
        if (st.internalTb) begin
            tick = 1'b1;
        end else begin
            tick = timebaseInput & ~st.tbPrev & (st.div == SSW_EXT_DIV_LAST);
        end
    end

    // APB phases
    always_comb begin
        setupRd  = apbReq.psel & ~apbReq.penable;
        accessWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
    end

    // Next-state logic
    always_comb begin
        next_st = st;
        // Two-stage synchroniser; first stage feeds only the second
        next_st.syncA = sense;
        next_st.syncB = st.syncA;

        // Time-base inputs are frozen while on backup supply
        if (!st.syncB.backup) begin
            next_st.internalTb = timebaseSelect;
            next_st.tbPrev     = timebaseInput;
            if (timebaseInput && !st.tbPrev && !st.internalTb) begin
                next_st.div = st.div + 6'h01;
            end
        end

        // Reset sequencer and watchdog
        case (st.phase)
            SSW_HOLD: begin
                next_st.cnt = '0;
                if (!bad) begin
                    next_st.phase = SSW_STRETCH;
                end
            end
            SSW_STRETCH: begin
                if (bad) begin
                    next_st.phase = SSW_HOLD;
                end else if (tick) begin
                    if (st.cnt >= stretchLimit - 28'h0000001) begin
                        next_st.phase       = SSW_RUN;
                        next_st.firstPeriod = 1'b1;
                        next_st.wdCnt       = '0;
                    end else begin
                        next_st.cnt = st.cnt + 28'h0000001;
                    end
                end
            end
            SSW_RUN: begin
                if (bad) begin
                    next_st.phase = SSW_HOLD;
                    // Clear now so no count outlives the run
                    next_st.wdCnt = '0;
                end else if (kickFloat) begin
                    next_st.wdCnt = '0;
                end else if (kickEdge) begin
                    next_st.wdCnt       = '0;
                    next_st.firstPeriod = 1'b0;
                end else if (tick) begin
                    if (st.wdCnt >= wdLimit - 28'h0000001) begin
                        next_st.expired = 1'b1;
                        next_st.phase   = SSW_STRETCH;
                        next_st.cnt     = '0;
                        next_st.wdCnt   = '0;
                    end else begin
                        next_st.wdCnt = st.wdCnt + 28'h0000001;
                    end
                end
            end
            default: begin
                next_st.phase = SSW_HOLD;
            end
        endcase

        // Counter stays clear outside the running phase
        if (st.phase != SSW_RUN) begin
            next_st.wdCnt = '0;
        end
        if (!st.syncB.backup) begin
            next_st.kickPrev = {kickHigh, kickLow};
        end

        // Expiry clears on kick edge or supply drop; a new expiry wins
        if ((kickEdge && !st.syncB.backup) || bad) begin
            next_st.expired = 1'b0;
        end
        if (st.phase == SSW_RUN && !bad && !kickFloat && !kickEdge && tick
            && st.wdCnt >= wdLimit - 28'h0000001) begin
            next_st.expired = 1'b1;
        end

        // Registered pin outputs
        next_st.pins.resetN        = (next_st.phase == SSW_RUN);
        next_st.pins.supplyOk      = ~bad;
        next_st.pins.expiryN       = ~next_st.expired;
        next_st.pins.powerFailFlag = st.syncB.pfAbove & ~st.syncB.backup;
        next_st.pins.backupActive  = st.syncB.backup;
        next_st.pins.memSelectOutN = bad ? 1'b1 : memSelectInN;

        // Register writes take effect in the access phase
        if (accessWr && apbReq.paddr == SSW_CTRL_ADDR) begin
            next_st.longVariant = apbReq.pwdata[SSW_CTRL_LONG_BIT];
        end

        // Read data and error are prepared in the setup phase
        if (setupRd) begin
            next_st.rdata = '0;
            next_st.rerr  = 1'b0;
            case (apbReq.paddr)
                SSW_CTRL_ADDR: begin
                    next_st.rdata[SSW_CTRL_LONG_BIT] = st.longVariant;
                end
                SSW_STATUS_ADDR: begin
                    next_st.rdata[9:0] = {st.firstPeriod, st.internalTb,
                                          st.phase, st.pins};
                end
                default: begin
                    next_st.rerr = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st             <= '0;
            st.phase       <= SSW_HOLD;
            st.longVariant <= SSW_CTRL_RESET;
            st.internalTb  <= 1'b1;
            st.firstPeriod <= 1'b1;
            st.pins        <= '{resetN: 1'b0, supplyOk: 1'b0, expiryN: 1'b1,
                               powerFailFlag: 1'b0, backupActive: 1'b0,
                               memSelectOutN: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    // Outputs; zero wait states, so pready stays high
    // Error shows only in the access phase, where the master samples it
    assign pins      = st.pins;
    assign resetHigh = ~st.pins.resetN;
    assign prdata    = st.rdata;
    assign pslverr   = st.rerr & apbReq.psel & apbReq.penable;
    assign pready    = 1'b1;

    // Checks
    inv_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        resetHigh == !pins.resetN) else $error("reset outputs not inverse");
    pf_backup_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.syncB.backup |=> !pins.powerFailFlag) else $error("pf flag high in backup");
    pf_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!st.syncB.backup && st.syncB.pfAbove) |=> pins.powerFailFlag)
        else $error("pf flag not following sense");
    reset_bad_a: assert property (@(posedge clk) disable iff (!rst_n)
        bad |=> !pins.resetN) else $error("reset not asserted on bad supply");
    supply_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
        bad != $past(bad) |-> ##1 pins.supplyOk == !$past(bad))
        else $error("supply ok not tracking");
    mem_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.syncB.supplyLow |=> pins.memSelectOutN) else $error("memory select not gated");
    // The release edge still loads reset values, so start one edge later
    sync_path_a: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n |-> ##2 st.syncB == $past(sense, 2)) else $error("sense sync not two stages");
    float_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (kickFloat && st.phase == SSW_RUN) |=> st.wdCnt == 28'h0000000)
        else $error("watchdog counts while floating");
    kick_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        (kickEdge && st.phase == SSW_RUN && !bad) |=> st.wdCnt == 28'h0000000 && pins.expiryN)
        else $error("kick edge did not restart");
    expire_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pins.expiryN) |-> !pins.resetN) else $error("expiry without reset");
    first_long_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(pins.resetN) |-> st.firstPeriod
            && (!st.internalTb || wdLimit == 28'(WD_LONG_CYC)))
        else $error("first period not long");

    // Reset stays low for the whole stretch, including a watchdog pulse
    stretch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.phase == SSW_STRETCH |-> !pins.resetN)
        else $error("reset released during stretch");
    wd_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(pins.expiryN) |-> st.phase == SSW_STRETCH && st.cnt == 28'h0000000)
        else $error("expiry did not start a stretch");

    // Supply-ok rises at once while reset still stretches
    ok_early_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && $fell(bad)) |=> pins.supplyOk && !pins.resetN)
        else $error("supply ok waited for stretch");

    // Counter stays clear whenever the processor is held in reset
    wd_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.phase != SSW_RUN |=> st.wdCnt == 28'h0000000)
        else $error("watchdog counts outside run");
    float_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (kickFloat && st.phase == SSW_RUN && !bad) |=> !$fell(pins.expiryN))
        else $error("expiry while kick floating");

    // A kick edge or a supply drop lifts the expiry output
    expiry_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        ((kickEdge && !st.syncB.backup) || bad) |=> pins.expiryN)
        else $error("expiry not cleared");

    // Memory select only passes on a good supply; backup ignores inputs
    mem_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && !bad) |=> pins.memSelectOutN == $past(memSelectInN))
        else $error("memory select not following");
    backup_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.syncB.backup |=> pins.memSelectOutN && pins.expiryN)
        else $error("inputs not ignored in backup");
    backup_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st.syncB.backup) |=> pins.backupActive)
        else $error("backup not indicated");

    // Time base: select pin, fixed external counts, prescaler wrap
    tb_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rst_n && !st.syncB.backup) |=> st.internalTb == $past(timebaseSelect))
        else $error("time base select not taken");
    ext_stretch_a: assert property (@(posedge clk) disable iff (!rst_n)
        !st.internalTb |-> stretchLimit == SSW_EXT_STRETCH)
        else $error("external stretch count wrong");
    long_stretch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.internalTb && st.longVariant) |-> stretchLimit == 28'(STRETCH_LONG_CYC))
        else $error("long stretch not chosen");
    short_wd_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.internalTb && !st.firstPeriod && !timebaseInput)
            |-> wdLimit == 28'(WD_SHORT_CYC))
        else $error("short timeout not chosen");
    ext_div_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!st.internalTb && !st.syncB.backup && tick) |=> st.div == 6'h00)
        else $error("prescaler not wrapping on tick");

    // Main scenarios

    expiry_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(pins.expiryN));
    release_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(pins.resetN));
    backup_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(pins.backupActive));
    ext_tick_c: cover property (@(posedge clk) disable iff (!rst_n) !st.internalTb && tick);
    float_c: cover property (@(posedge clk) disable iff (!rst_n) kickFloat && st.phase == SSW_RUN);

endmodule // ssw_supervisor

/* testbench/ssw_cpu_model.sv */
// Processor-side model that services the three-level watchdog kick.
// Assumes the supervisor's active-low reset is fed back so kicking stalls in reset.
`timescale 1ns/100ps

module ssw_cpu_model #(
    parameter int KICK_GAP = 30
) (
    input  wire logic clk,
    input  wire logic resetN,
    input  wire logic floatKick,
    input  wire logic holdKick,
    output logic      kickHigh = 1'b0,
    output logic      kickLow = 1'b0
);
    int gap = 0;

    // A real processor only services the watchdog while out of reset
    always @(posedge clk) begin
        gap <= gap + 1;
        if (floatKick) begin
            kickHigh <= 1'b0;
            kickLow  <= 1'b0;
        end else if (!kickHigh && !kickLow) begin
            kickHigh <= 1'b1;
            gap      <= 0;
        end else if (resetN && !holdKick && gap >= KICK_GAP - 1) begin
            kickHigh <= kickLow;
            kickLow  <= kickHigh;
            gap      <= 0;
        end
    end
endmodule // ssw_cpu_model

/* testbench/ssw_supervisor_test.sv */
// Self-checking bench for the supply supervisor core.
// Assumes the package and core under src/ and the processor model beside it.
`timescale 1ns/100ps

module ssw_supervisor_test;
    import ssw_pkg::*;
    localparam int STR  = 20;
    localparam int STRL = 40;
    localparam int WDL  = 200;
    localparam int WDS  = 50;
    localparam int EXTP = 4;    // Cycles per external time-base period

    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    ssw_sense_t   sense = 3'b101;
    logic         timebaseSelect = 1'b1;
    logic         timebaseInput = 1'b1;
    logic         memSelectInN = 1'b1;
    logic         floatKick = 1'b1;
    logic         holdKick = 1'b0;
    logic         extOn = 1'b0;
    logic         extClk = 1'b0;
    ssw_apb_req_t apbReq = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         kickHigh;
    logic         kickLow;
    logic         resetHigh;
    ssw_pins_t    pins;
    int           err_total = 0;
    int           cmp_count = 0;
    int           cycles = 0;
    int           n;
    logic [31:0]  rd;
    logic         perr;

    always #5 clk = ~clk;

    ssw_supervisor #(.STRETCH_SHORT_CYC(STR), .STRETCH_LONG_CYC(STRL),
        .WD_LONG_CYC(WDL), .WD_SHORT_CYC(WDS)) uut (.clk(clk), .rst_n(rst_n),
        .sense(sense), .kickHigh(kickHigh), .kickLow(kickLow),
        .timebaseSelect(timebaseSelect), .timebaseInput(extOn ? extClk : timebaseInput),
        .memSelectInN(memSelectInN), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .resetHigh(resetHigh));

    ssw_cpu_model cpu (.clk(clk), .resetN(pins.resetN), .floatKick(floatKick),
        .holdKick(holdKick), .kickHigh(kickHigh), .kickLow(kickLow));

    // External time base and the hang limit share one cycle counter
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles[0]) extClk <= ~extClk;
        if (cycles == 20000) begin
            $display("mismatch at %0t: run timed out", $time);
            err_total = err_total + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic chkRange(input int v, input int lo, input int hi, input string what);
        cmp_count++;
        if (v < lo || v > hi) begin
            err_total++;
            $display("mismatch at %0t: %s took %0d cycles", $time, what, v);
        end
    endtask

    // Sample after the edge so registered outputs have landed
    task automatic samp(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic waitReset(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (pins.resetN !== lvl && cnt < lim) begin
            samp(1);
            cnt++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic err);
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        apbReq <= '0;
    endtask

    // Drop the supply, check the forced outputs, then time the stretch
    task automatic outage(input int lo, input int hi);
        @(posedge clk);
        sense.supplyLow <= 1'b1;
        memSelectInN <= 1'b0;
        samp(4);
        chk(pins.resetN, 1'b0, "reset not asserted on low supply");
        chk(resetHigh, 1'b1, "high reset not inverse");
        chk(pins.supplyOk, 1'b0, "supply ok not low");
        chk(pins.memSelectOutN, 1'b1, "memory select not gated");
        @(posedge clk);
        sense.supplyLow <= 1'b0;
        samp(4);
        chk(pins.supplyOk, 1'b1, "supply ok held by stretch");
        chk(pins.memSelectOutN, 1'b0, "memory select not following");
        waitReset(1'b1, hi + 10, n);
        chkRange(n, lo, hi, "stretch");
        chk(resetHigh, 1'b0, "high reset not inverse");
    endtask

    task automatic powerFail();
        @(posedge clk);
        sense.pfAbove <= 1'b0;
        samp(4);
        chk(pins.powerFailFlag, 1'b0, "flag high below reference");
        @(posedge clk);
        sense <= 3'b011;
        samp(4);
        chk(pins.powerFailFlag, 1'b0, "flag not forced low on backup");
        chk(pins.backupActive, 1'b1, "backup not indicated");
        chk(pins.resetN, 1'b0, "reset not asserted on backup");
        chk(pins.supplyOk, 1'b0, "supply ok high on backup");
        chk(pins.memSelectOutN, 1'b1, "memory select passed on backup");
        @(posedge clk);
        sense <= 3'b001;
        samp(4);
        chk(pins.powerFailFlag, 1'b1, "flag low above reference");
        chk(pins.backupActive, 1'b0, "backup still indicated");
        waitReset(1'b1, STR + 10, n);
    endtask

    // Kick steadily, stall the kick, then time expiry and repeated pulses
    task automatic wdExpire(input logic longSel, input int lo, input int hi);
        @(posedge clk);
        timebaseInput <= longSel;
        floatKick <= 1'b0;
        holdKick <= 1'b0;
        waitReset(1'b0, 300, n);
        chkRange(n, 300, 300, "reset while kicked");
        @(posedge clk);
        holdKick <= 1'b1;
        waitReset(1'b0, hi + 10, n);
        chkRange(n, lo, hi, "timeout");
        chk(pins.expiryN, 1'b0, "expiry not low");
        waitReset(1'b1, STR + 10, n);
        chkRange(n, STR - 3, STR + 6, "watchdog reset pulse");
        waitReset(1'b0, WDL + 10, n);
        chkRange(n, WDL - 3, WDL + 6, "first period after reset");
        waitReset(1'b1, STR + 10, n);
        @(posedge clk);
        holdKick <= 1'b0;
        samp(4);
        chk(pins.expiryN, 1'b1, "expiry not cleared by kick");
        @(posedge clk);
        floatKick <= 1'b1;
        waitReset(1'b0, 3 * WDL, n);
        chkRange(n, 3 * WDL, 3 * WDL, "watchdog ran while floating");
    endtask

    initial begin
        repeat (7) @(posedge clk);
        #1;
        chk(pins.resetN, 1'b0, "reset value of reset");
        chk(resetHigh, 1'b1, "reset value of high reset");
        chk(pins.expiryN, 1'b1, "reset value of expiry");
        chk(pins.memSelectOutN, 1'b1, "reset value of memory select");
        @(posedge clk);
        rst_n <= 1'b1;
        outage(STR - 3, STR + 6);
        powerFail();
        wdExpire(1'b0, WDS - 32, WDS + 6);
        wdExpire(1'b1, WDL - 32, WDL + 6);
        apb(1'b1, SSW_CTRL_ADDR, 32'h00000001, rd, perr);
        apb(1'b0, SSW_CTRL_ADDR, 32'h0, rd, perr);
        chk(rd[0], 1'b1, "long variant bit not stored");
        chk(perr, 1'b0, "mapped read refused");
        apb(1'b0, SSW_STATUS_ADDR, 32'h0, rd, perr);
        chk(rd[5] & rd[4] & rd[7] & !rd[6], 1'b1, "status shows no run");
        apb(1'b0, 8'h08, 32'h0, rd, perr);
        chk(perr & (rd == 32'h0), 1'b1, "unmapped read not refused");
        outage(STRL - 3, STRL + 6);
        @(posedge clk);
        timebaseSelect <= 1'b0;
        extOn <= 1'b1;
        outage(15 * 64 * EXTP - 8, 17 * 64 * EXTP + 8);
        stop_test();
    end
endmodule // ssw_supervisor_test
